/* File: inc/vof_consts.svh */
// Purpose: constants of the video output formatter
// Assumes: 10-bit samples, 32-bit AHB-Lite register words
// Notes:   offsets are byte addresses within the block
`ifndef VOF_CONSTS_SVH
`define VOF_CONSTS_SVH

`define VOF_ADDR_CTRL   8'h00
`define VOF_ADDR_LINE   8'h04
`define VOF_ADDR_ACT    8'h08
`define VOF_ADDR_BURST  8'h0C
`define VOF_ADDR_VBLANK 8'h10
`define VOF_ADDR_LIMIT  8'h14
`define VOF_ADDR_AUX    8'h18
`define VOF_ADDR_STATUS 8'h1C

`define VOF_RST_CTRL    15'h0000
`define VOF_RST_LINELEN 12'h06B4
`define VOF_RST_SAV     12'h010C
`define VOF_RST_EAV     12'h06AC
`define VOF_RST_BURST   12'h0028
`define VOF_RST_VACT    10'h006
`define VOF_RST_FRAME_BLANK_N    10'h104
`define VOF_RST_LIMLO   10'h040
`define VOF_RST_LIMHI   10'h3AC
`define VOF_RST_AUX     10'h000

`define VOF_BLANK_Y     10'h040
`define VOF_BLANK_C     10'h200
`define VOF_TRS_ONES    10'h3FF
`define VOF_TRS_ZERO    10'h000
`define VOF_TRS_LEN     12'h0004
`define VOF_BURST_LEN   12'h0010
`define VOF_PAL_LINE    10'h136
`define VOF_NTSC_LINE   10'h103
`define VOF_RND_MAX     10'h3FC

`endif

/* File: inc/vof_pkg.sv */
// Purpose: types of the video output formatter
// Assumes: 10-bit samples
// Notes:   control word layout matches the CTRL register bits
package vof_pkg;
  typedef enum logic [1:0] {VOF_FMT_RGB, VOF_FMT_YUV, VOF_FMT_YC, VOF_FMT_RSV} vof_fmt_type;
  typedef enum logic [1:0] {VOF_STD_NTSC, VOF_STD_PAL, VOF_STD_PALM, VOF_STD_RSV} vof_std_type;

  typedef struct packed {
    logic        comb3;
    vof_std_type std;
    vof_fmt_type fmt;
    logic        output_clock_select;
    logic        hr_dir;
    logic        cb_sel;
    logic        embed;
    logic        dual422;
    logic        decim;
    logic        aux_en;
    logic        round8;
    logic        msb_inv;
    logic        kill;
  } vof_ctrl_type;

  typedef struct packed {
    logic [9:0] y;
    logic [9:0] cb;
    logic [9:0] cr;
  } vof_pix_type;

  typedef struct packed {
    logic [9:0] a;
    logic [9:0] b;
    logic [9:0] c;
  } vof_bus_type;
endpackage : vof_pkg

/* File: hdl/vof_top.sv */
// Purpose: output formatting and sync pulse timing of the video decoder
// Assumes: CLK is the double pixel rate clock; syncs and half-rate pin are asynchronous
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "vof_consts.svh"

module vof_top (
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic               HSEL,
  input  wire logic [31:0]        HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire logic [31:0]        HWDATA,
  input  wire logic               HREADY,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  output logic [31:0]             HRDATA,
  input  wire vof_pkg::vof_pix_type PIX_IN,
  input  wire logic               HSYNC_N,
  input  wire logic               VSYNC_N,
  input  wire logic               HALF_RATE_CLOCK_PIN_IN,
  output logic                    HALF_RATE_CLOCK_PIN_OUT,
  output logic                    HALF_RATE_CLOCK_PIN_OE_N,
  output vof_pkg::vof_bus_type    OUT_BUS,
  output logic                    OUT_STROBE,
  output logic                    LINE_BLANK_N,
  output logic                    FRAME_BLANK_N,
  output logic                    MIXED_BLANK_N,
  output logic                    FIELD_FLAG,
  output logic                    FIRST_HALF_ACTIVE,
  output logic                    SECOND_HALF_ACTIVE,
  output logic                    BURST_GATE,
  output logic                    SYSTEM_PHASE_CLEAR
);
  import vof_pkg::*;

  vof_ctrl_type ctrl;
  logic [11:0]  line_len;
  logic [11:0]  sav;
  logic [11:0]  eav;
  logic [11:0]  burst_pos;
  logic [9:0]   v_act;
  logic [9:0]   v_blk;
  logic [9:0]   lim_lo;
  logic [9:0]   lim_hi;
  logic [9:0]   aux;
  logic         wr_pend;
  logic [7:0]   addr_q;
  logic [2:0]   s1, s2, s3, lvl, lvl_q;
  logic         hs_fall, vs_fall, hr_rise, hr_div, pix_en;
  logic [11:0]  hcount, bcount;
  logic [9:0]   line;
  logic         field, phase;
  logic [9:0]   iline;
  logic         hact, in_eav, in_savp, gap, fha, sha;
  logic [11:0]  mid, k_eav, k_sav, k_act, k_gap;
  logic         next_fblank_n, special;
  vof_pix_type  p;
  vof_bus_type  next_out;
  logic [9:0]   d1_word;
  logic [9:0]   xyz;

  function automatic logic [9:0] round_to_byte(input logic [9:0] v);
    logic [10:0] s;
    s = {1'b0, v} + 11'h002;
    round_to_byte = s[10] ? `VOF_RND_MAX : {s[9:2], 2'b00};
  endfunction : round_to_byte

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_pend <= 1'b0;
      addr_q  <= 8'h00;
    end else if (HREADY) begin
      wr_pend <= HSEL && HTRANS[1] && HWRITE;
      addr_q  <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl      <= vof_ctrl_type'(`VOF_RST_CTRL);
      line_len  <= `VOF_RST_LINELEN;
      sav       <= `VOF_RST_SAV;
      eav       <= `VOF_RST_EAV;
      burst_pos <= `VOF_RST_BURST;
      v_act     <= `VOF_RST_VACT;
      v_blk     <= `VOF_RST_FRAME_BLANK_N;
      lim_lo    <= `VOF_RST_LIMLO;
      lim_hi    <= `VOF_RST_LIMHI;
      aux       <= `VOF_RST_AUX;
    end else if (wr_pend) begin
      unique case (addr_q)
        `VOF_ADDR_CTRL:   ctrl <= vof_ctrl_type'(HWDATA[14:0]);
        `VOF_ADDR_LINE:   line_len <= HWDATA[11:0];
        `VOF_ADDR_ACT: begin
          sav <= HWDATA[11:0];
          eav <= HWDATA[27:16];
        end
        `VOF_ADDR_BURST:  burst_pos <= HWDATA[11:0];
        `VOF_ADDR_VBLANK: begin
          v_act <= HWDATA[9:0];
          v_blk <= HWDATA[25:16];
        end
        `VOF_ADDR_LIMIT: begin
          lim_lo <= HWDATA[9:0];
          lim_hi <= HWDATA[25:16];
        end
        `VOF_ADDR_AUX:    aux <= HWDATA[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      HRDATA <= 32'h0000_0000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      unique case (HADDR[7:0])
        `VOF_ADDR_CTRL:   HRDATA <= {17'h0_0000, ctrl};
        `VOF_ADDR_LINE:   HRDATA <= {20'h0_0000, line_len};
        `VOF_ADDR_ACT:    HRDATA <= {4'h0, eav, 4'h0, sav};
        `VOF_ADDR_BURST:  HRDATA <= {20'h0_0000, burst_pos};
        `VOF_ADDR_VBLANK: HRDATA <= {6'h00, v_blk, 6'h00, v_act};
        `VOF_ADDR_LIMIT:  HRDATA <= {6'h00, lim_hi, 6'h00, lim_lo};
        `VOF_ADDR_AUX:    HRDATA <= {22'h00_0000, aux};
        `VOF_ADDR_STATUS: HRDATA <= {19'h0_0000, FIELD_FLAG, FRAME_BLANK_N, LINE_BLANK_N, iline};
        default:          HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge CLK) begin
    if (RST) begin
      s1    <= 3'b011;
      s2    <= 3'b011;
      s3    <= 3'b011;
      lvl   <= 3'b011;
      lvl_q <= 3'b011;
    end else begin
      s1    <= {HALF_RATE_CLOCK_PIN_IN, VSYNC_N, HSYNC_N};
      s2    <= s1;
      s3    <= s2;
      lvl   <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl);
      lvl_q <= lvl;
    end
  end

  assign hs_fall = lvl_q[0] && !lvl[0];
  assign vs_fall = lvl_q[1] && !lvl[1];

  ////////////////////////////////////////////////////////////////////////////
  // half-rate clock and output pacing
  always_ff @(posedge CLK) begin
    if (RST) begin
      hr_div <= 1'b0;
    end else begin
      hr_div <= !hr_div;
    end
  end

  assign HALF_RATE_CLOCK_PIN_OUT  = hr_div;
  assign HALF_RATE_CLOCK_PIN_OE_N = ctrl.hr_dir;
  assign hr_rise = ctrl.hr_dir ? (!lvl_q[2] && lvl[2]) : !hr_div;
  assign pix_en  = ctrl.output_clock_select ? hr_rise : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // sync pulse generator
  always_ff @(posedge CLK) begin
    if (RST) begin
      hcount <= 12'h000;
      line   <= 10'h000;
      field  <= 1'b0;
    end else begin
      if (hs_fall) begin
        hcount <= 12'h000;
      end else if (pix_en) begin
        hcount <= (hcount >= line_len - 12'h001) ? 12'h000 : hcount + 12'h001;
      end
      if (vs_fall) begin
        line  <= 10'h000;
        field <= hcount >= {1'b0, line_len[11:1]};
      end else if (hs_fall) begin
        line <= line + 10'h001;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      bcount <= 12'hFFF;
    end else if (hs_fall) begin
      bcount <= 12'h000;
    end else if (bcount != 12'hFFF) begin
      bcount <= bcount + 12'h001;
    end
  end

  assign iline   = line + {9'h000, ctrl.comb3};
  assign hact    = hcount >= sav && hcount < eav;
  assign in_eav  = hcount >= eav && hcount < eav + `VOF_TRS_LEN;
  assign in_savp = hcount >= sav - `VOF_TRS_LEN && hcount < sav;
  assign gap     = !hact && !in_eav && !in_savp;
  assign mid     = 12'((13'(sav) + 13'(eav)) >> 1);
  assign fha     = hact && hcount < mid;
  assign sha     = hact && hcount >= mid;
  assign next_fblank_n = !(iline < v_act || iline >= v_blk);
  assign special = (ctrl.std == VOF_STD_PAL && iline == `VOF_PAL_LINE && fha && field) ||
                   (ctrl.std != VOF_STD_PAL && iline == `VOF_NTSC_LINE && sha && !field);

  always_ff @(posedge CLK) begin
    if (RST) begin
      LINE_BLANK_N       <= 1'b0;
      FRAME_BLANK_N      <= 1'b0;
      MIXED_BLANK_N      <= 1'b0;
      FIELD_FLAG         <= 1'b0;
      FIRST_HALF_ACTIVE  <= 1'b0;
      SECOND_HALF_ACTIVE <= 1'b0;
      BURST_GATE         <= 1'b0;
    end else begin
      LINE_BLANK_N       <= hact;
      FRAME_BLANK_N      <= next_fblank_n;
      MIXED_BLANK_N      <= hact && next_fblank_n && !special;
      FIELD_FLAG         <= field;
      FIRST_HALF_ACTIVE  <= fha;
      SECOND_HALF_ACTIVE <= sha;
      BURST_GATE         <= bcount >= burst_pos && bcount < burst_pos + `VOF_BURST_LEN;
    end
  end

  assign SYSTEM_PHASE_CLEAR = !LINE_BLANK_N;

  ////////////////////////////////////////////////////////////////////////////
  // sample processing
  always_comb begin
    p = PIX_IN;
    if (ctrl.kill && (PIX_IN.y <= lim_lo || PIX_IN.y >= lim_hi)) begin
      p.cb = 10'h000;
      p.cr = 10'h000;
    end
    if (ctrl.round8) begin
      p.y  = round_to_byte(p.y);
      p.cb = round_to_byte(p.cb);
      p.cr = round_to_byte(p.cr);
    end
    if (ctrl.fmt == VOF_FMT_YC) begin
      p.cr = 10'h000;
    end
    if (ctrl.aux_en && !hact) begin
      p.y = aux;
    end
    if (ctrl.msb_inv) begin
      p.cb[9] = !p.cb[9];
      p.cr[9] = !p.cr[9];
    end
  end

  // chroma phase restarts at each active line start
  always_ff @(posedge CLK) begin
    if (RST) begin
      phase <= 1'b0;
    end else if (pix_en) begin
      phase <= (hcount == sav - 12'h001) ? ctrl.cb_sel : !phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // embedded D1 stream
  assign k_eav = hcount - eav;
  assign k_sav = hcount - (sav - `VOF_TRS_LEN);
  assign k_act = hcount - sav;
  assign k_gap = hcount - (eav + `VOF_TRS_LEN);
  assign xyz   = {1'b1, field, !next_fblank_n, in_eav, !next_fblank_n ^ in_eav,
                  field ^ in_eav, field ^ !next_fblank_n, field ^ !next_fblank_n ^ in_eav, 2'b00};

  always_comb begin
    d1_word = `VOF_TRS_ZERO;
    if (in_eav || in_savp) begin
      unique case (in_eav ? k_eav[1:0] : k_sav[1:0])
        2'd0:    d1_word = `VOF_TRS_ONES;
        2'd3:    d1_word = xyz;
        default: d1_word = `VOF_TRS_ZERO;
      endcase
    end else if (gap) begin
      d1_word = k_gap[0] ? `VOF_BLANK_Y : `VOF_BLANK_C;
    end else begin
      unique case (k_act[1:0])
        2'd0:    d1_word = p.cb;
        2'd2:    d1_word = p.cr;
        default: d1_word = p.y;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output bus selection
  always_comb begin
    next_out = {p.y, p.cb, p.cr};
    if (ctrl.decim && ctrl.embed) begin
      next_out.b = phase ? p.cr : p.cb;
      next_out.c = d1_word;
    end else if (ctrl.decim && ctrl.dual422) begin
      if (gap) begin
        next_out = {`VOF_BLANK_Y, `VOF_BLANK_C, 10'h000};
      end else begin
        next_out = {p.y, phase ? p.cr : p.cb, 10'h000};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      OUT_BUS    <= '0;
      OUT_STROBE <= 1'b0;
    end else begin
      OUT_STROBE <= pix_en;
      if (pix_en) begin
        OUT_BUS <= next_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_kill_chroma: assert property (@(posedge CLK) disable iff (RST)
    (pix_en && ctrl.kill && !ctrl.decim && !ctrl.msb_inv && PIX_IN.y >= lim_hi)
    |=> (OUT_BUS.b == 10'h000 && OUT_BUS.c == 10'h000))
    else $error("chroma not killed at luma limit");

  a_msb_flip: assert property (@(posedge CLK) disable iff (RST)
    (pix_en && ctrl.msb_inv && !ctrl.kill && !ctrl.round8 && !ctrl.decim)
    |=> OUT_BUS.b[9] == !$past(PIX_IN.cb[9]))
    else $error("chroma msb not inverted");

  a_round_byte: assert property (@(posedge CLK) disable iff (RST)
    (pix_en && ctrl.round8 && !ctrl.decim && !ctrl.msb_inv) |=> OUT_BUS.a[1:0] == 2'b00)
    else $error("luma not rounded to 8 bits");

  a_yc_zero: assert property (@(posedge CLK) disable iff (RST)
    (pix_en && ctrl.fmt == VOF_FMT_YC && !ctrl.msb_inv && !ctrl.decim) |=> OUT_BUS.c == 10'h000)
    else $error("bus c not zero in YC format");

  a_dual_blank: assert property (@(posedge CLK) disable iff (RST)
    (pix_en && ctrl.decim && ctrl.dual422 && !ctrl.embed && gap)
    |=> (OUT_BUS.a == `VOF_BLANK_Y && OUT_BUS.b == `VOF_BLANK_C))
    else $error("blanking codes wrong on dual bus");

  a_trs_preamble: assert property (@(posedge CLK) disable iff (RST)
    (ctrl.decim && ctrl.embed && !ctrl.output_clock_select && !hs_fall && hcount == eav)
    |=> OUT_BUS.c == `VOF_TRS_ONES ##1 OUT_BUS.c == `VOF_TRS_ZERO ##1 OUT_BUS.c == `VOF_TRS_ZERO)
    else $error("EAV preamble wrong");

  a_gap_first: assert property (@(posedge CLK) disable iff (RST)
    (pix_en && ctrl.decim && ctrl.embed && gap && k_gap == 12'h000) |=> OUT_BUS.c == `VOF_BLANK_C)
    else $error("gap does not start with 512");

  a_burst_len: assert property (@(posedge CLK) disable iff (RST)
    ($rose(BURST_GATE) && !hs_fall) |-> (BURST_GATE && !hs_fall)[*8] ##1 BURST_GATE[*8] ##1 !BURST_GATE)
    else $error("burst gate not 16 clocks");

  a_mixed_blank: assert property (@(posedge CLK) disable iff (RST)
    (!LINE_BLANK_N || !FRAME_BLANK_N) |-> !MIXED_BLANK_N)
    else $error("mixed blank missed a blanking period");

  a_half_active: assert property (@(posedge CLK) disable iff (RST)
    SECOND_HALF_ACTIVE |-> (LINE_BLANK_N && !FIRST_HALF_ACTIVE))
    else $error("second half active outside active line");

  a_phase_clear: assert property (@(posedge CLK) disable iff (RST)
    !hact |=> SYSTEM_PHASE_CLEAR)
    else $error("phase offset not cleared in blanking");

endmodule : vof_top
`default_nettype wire

/* File: dv/vof_sink_model.sv */
// Purpose: downstream video logic facing the formatter output
// Assumes: external half-rate clock of 80 ns, unrelated in phase to CLK
// Notes:   counts every strobed output word
`timescale 1ns/100ps
`default_nettype none
module vof_sink_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        oe_n,
  input  wire logic        pin_out,
  input  wire logic        strobe,
  output logic             pin_level,
  output logic [15:0]      n_words
);
  logic ext_clk = 1'b0;

  // clock stands low while the formatter drives the pin
  initial begin
    #1.3;
    forever #40 ext_clk = oe_n ? ~ext_clk : 1'b0;
  end

  // resolved level of the shared pin
  assign pin_level = oe_n ? ext_clk : pin_out;

  always_ff @(posedge clk) begin
    if (rst) n_words <= '0;
    else if (strobe) n_words <= n_words + 16'h0001;
  end
endmodule : vof_sink_model
`default_nettype wire

/* File: dv/video_output_formatter_tb.sv */
// Purpose: self-checking bench of the video output formatter
// Assumes: CLK 250 MHz, AHB-Lite single word transfers
// Notes:   output words are keyed by their place relative to line blanking
`timescale 1ns/100ps
`default_nettype none
module video_output_formatter_tb;
  import vof_pkg::*;
  typedef struct {int k; int w; logic [9:0] e;} vof_note_type;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          hsel = 1'b0;
  logic          hwrite = 1'b0;
  logic          vsync_n = 1'b1;
  logic          hsync_n = 1'b1;
  logic [1:0]    htrans = 2'h0;
  logic [31:0]   haddr = 32'h0000_0000;
  logic [31:0]   hwdata = 32'h0000_0000;
  logic [31:0]   hrdata;
  logic [31:0]   rd;
  logic          hready;
  logic          pin_out;
  logic          pin_lvl;
  logic          oe_n;
  logic          strobe;
  logic          lbn;
  logic          mbn;
  logic          spc;
  logic          fbn;
  logic          fha;
  logic          sha;
  logic          bgate;
  logic [15:0]   n_words;
  logic [15:0]   w0;
  logic [9:0]    y, cb, cr, ea, eb, ec, seen;
  vof_pix_type   pix = '0;
  vof_bus_type   ob;
  vof_note_type  notes[$];
  int            mismatches = 0;
  int            n_tests = 0;
  int            pos = 1000;
  int            cyc = 0;
  int            seed = 63;
  int            b0 = 0;
  int            b1 = 0;
  logic [7:0]    ra [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h20};
  logic [31:0]   rv [5] = '{32'h0000_0000, 32'h0000_06B4, 32'h06AC_010C, 32'h03AC_0040, 32'h0000_0000};
  logic [14:0]   cv [7] = '{15'h0000, 15'h0001, 15'h0002, 15'h0004, 15'h0800, 15'h0001, 15'h0001};
  logic [9:0]    d1 [8] = '{10'h3FF, 10'h000, 10'h000, 10'h2D8, 10'h200, 10'h040, 10'h200, 10'h040};
  logic [31:0]   ck [3] = '{32'h0000_0000, 32'h0000_0200, 32'h0000_0300};
  logic [31:0]   nw [3] = '{32'h0000_00C8, 32'h0000_0064, 32'h0000_000A};

  // line-locked double-rate word clock
  always #2 clk = ~clk;

  vof_top u_vof_top (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(), .HRDATA(hrdata),
    .PIX_IN(pix), .HSYNC_N(hsync_n), .VSYNC_N(vsync_n), .HALF_RATE_CLOCK_PIN_IN(pin_lvl),
    .HALF_RATE_CLOCK_PIN_OUT(pin_out), .HALF_RATE_CLOCK_PIN_OE_N(oe_n), .OUT_BUS(ob), .OUT_STROBE(strobe),
    .LINE_BLANK_N(lbn), .FRAME_BLANK_N(fbn), .MIXED_BLANK_N(mbn), .FIELD_FLAG(), .FIRST_HALF_ACTIVE(fha),
    .SECOND_HALF_ACTIVE(sha), .BURST_GATE(bgate), .SYSTEM_PHASE_CLEAR(spc));

  vof_sink_model u_vof_sink_model (.clk(clk), .rst(rst), .oe_n(oe_n), .pin_out(pin_out), .strobe(strobe),
    .pin_level(pin_lvl), .n_words(n_words));

  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic note(input int k, input int w, input logic [9:0] e);
    notes.push_back('{k, w, e});
  endtask : note

  // let mode and sample changes reach the output
  task automatic settle();
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic drain();
    repeat (4000) if (notes.size() != 0) @(posedge clk);
    check("pending notes", notes.size(), 0);
    notes.delete();
    @(posedge clk);
  endtask : drain

  task automatic wait_lbn(input logic v);
    repeat (4000) if (lbn !== v) @(posedge clk);
  endtask : wait_lbn

  function automatic logic [9:0] rnd(input logic [9:0] v);
    logic [10:0] s;
    s = {1'b0, v} + 11'h002;
    return (s > 11'h3FC) ? 10'h3FC : (s[9:0] & 10'h3FC);
  endfunction : rnd

  ////////////////////////////////////////////////////////////
  // place: 0.. from blanking start, -1.. from first active word
  always @(posedge clk) begin
    if (!rst && strobe === 1'b1) begin
      if (lbn === 1'b1) pos = (pos >= 0) ? -1 : pos - 1;
      else pos = (pos < 0) ? 0 : pos + 1;
      while (notes.size() != 0 && notes[0].k == pos) begin
        seen = notes[0].w == 0 ? ob.a : notes[0].w == 1 ? ob.b : notes[0].w == 2 ? ob.c
             : notes[0].w == 3 ? {9'h000, spc} : notes[0].w == 4 ? {9'h000, mbn} : {8'h00, fha, sha};
        check($sformatf("output %0d", notes[0].w), seen, notes[0].e);
        void'(notes.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, ra[i], 32'h0000_0000);
      check("register", rd, rv[i]);
    end
    for (int i = 0; i < 7; i++) begin
      y = 10'h080 + 10'($random(seed) & 32'h0000_01FF);
      cb = 10'($random(seed));
      cr = 10'($random(seed));
      if (i == 1) y = 10'h3AC;
      if (i == 3) y = 10'h3FE;
      if (i == 5) y = 10'h040;
      if (i == 6) y = 10'h041;
      pix <= '{y, cb, cr};
      ahb(1'b1, 8'h00, {17'h0_0000, cv[i]});
      ea = (i == 3) ? 10'h3FC : y;
      eb = (i == 1 || i == 5) ? 10'h000 : (i == 2) ? cb ^ 10'h200 : (i == 3) ? rnd(cb) : cb;
      ec = (i == 1 || i == 5 || i == 4) ? 10'h000 : (i == 2) ? cr ^ 10'h200 : (i == 3) ? rnd(cr) : cr;
      settle();
      note(-5, 0, ea);
      note(-5, 1, eb);
      note(-5, 2, ec);
      drain();
    end
    ahb(1'b1, 8'h18, 32'h0000_0155);
    for (int f = 0; f < 2; f++) begin
      ahb(1'b1, 8'h00, f ? 32'h0000_0408 : 32'h0000_0008);
      settle();
      note(4, 0, 10'h155);
      note(4, 1, cb);
      note(-5, 0, y);
      drain();
    end
    for (int s = 0; s < 2; s++) begin
      ahb(1'b1, 8'h00, s ? 32'h0000_00B0 : 32'h0000_0030);
      settle();
      note(4, 0, 10'h040);
      note(4, 1, 10'h200);
      note(5, 0, 10'h040);
      note(5, 1, 10'h200);
      note(-1, 1, s ? cr : cb);
      note(-1, 2, 10'h000);
      note(-2, 1, s ? cb : cr);
      drain();
    end
    ahb(1'b1, 8'h00, 32'h0000_0050);
    settle();
    note(0, 3, 10'h001);
    note(0, 4, 10'h000);
    for (int k = 0; k < 8; k++) note(k, 2, d1[k]);
    note(272, 2, 10'h3FF);
    note(275, 2, 10'h2AC);
    note(-1, 2, cb);
    note(-2, 2, y);
    note(-3, 2, cr);
    note(-4, 2, y);
    note(-5, 3, 10'h000);
    note(-720, 5, 10'h002);
    note(-721, 5, 10'h001);
    drain();
    for (int i = 0; i < 2; i++) begin
      ahb(1'b1, 8'h00, i ? 32'h0000_4000 : 32'h0000_0000);
      wait_lbn(1'b0);
      wait_lbn(1'b1);
      repeat (i ? 700 : 10) @(posedge clk);
      vsync_n <= 1'b0;
      repeat (4) @(posedge clk);
      vsync_n <= 1'b1;
      repeat (30) @(posedge clk);
      ahb(1'b0, 8'h1C, 32'h0000_0000);
      check("field", rd[12], i[0]);
      check("line", rd[9:0], 10'(i));
      check("frame blank", fbn, 1'b0);
    end
    // one sync pulse: burst gate place and length, line advance
    hsync_n <= 1'b0;
    repeat (4) @(posedge clk);
    hsync_n <= 1'b1;
    repeat (100) begin
      @(posedge clk);
      if (bgate === 1'b1) b1++;
      else if (b1 == 0) b0++;
    end
    check("burst start", b0 >= 36 && b0 <= 44, 1'b1);
    check("burst length", b1, 16);
    ahb(1'b0, 8'h1C, 32'h0000_0000);
    check("line step", rd[9:0], 10'h002);
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, 8'h00, ck[i]);
      repeat (40) @(posedge clk);
      w0 = n_words;
      repeat (200) @(posedge clk);
      check("words", 16'(n_words - w0), nw[i]);
      check("pin drive", oe_n, i == 2);
    end
    conclude();
  end
endmodule : video_output_formatter_tb
`default_nettype wire
